// ### verilog/pbs_defs.svh
// Register offsets, field positions, reset values and command codes of the peer unit.
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_OFF_STATUS    12'h000
`define PBS_OFF_COMMAND   12'h004
`define PBS_OFF_NODE      12'h008
`define PBS_OFF_RATE      12'h00C
`define PBS_OFF_SRC_NODE  12'h010
`define PBS_OFF_COUNT     12'h014
`define PBS_OFF_FIRST     12'h018
`define PBS_OFF_OVERFLOW  12'h01C
`define PBS_WIN_PAGE      4'h1
`define PBS_BIT_BUS_ERR   12
`define PBS_BIT_BUSY      13
`define PBS_BIT_OVF       14
`define PBS_BIT_PARAM     15
`define PBS_BIT_ALARM     16
`define PBS_BIT_TERM_OFF  22
`define PBS_BIT_PEER      23
`define PBS_CMD_INIT      8'h0A
`define PBS_CMD_SEND      8'h0B
`define PBS_CMD_COPY      8'h0C
`define PBS_CMD_TERM_OFF  8'h0D
`define PBS_CMD_TERM_ON   8'h0E
`define PBS_NODE_MIN      8'h02
`define PBS_NODE_MAX      8'h0D
`define PBS_RATE_MIN      8'h04
`define PBS_RATE_MAX      8'h07
`define PBS_RATE_RESET    8'h07
`define PBS_COUNT_MAX     8'h40
`define PBS_FIRST_MAX     8'h3F
`define PBS_TERM_REV      8'h02
`endif

// ### verilog/pbs_pkg.sv
// Types shared by the peer status and command unit.
package pbs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_COPY} pbs_state_t;
	typedef struct packed {
		logic        valid;
		logic [5:0]  index;
		logic [23:0] data;
	} pbs_tx_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] node;
		logic [5:0] index;
	} pbs_fetch_t;
	typedef struct packed {
		logic        valid;
		logic [23:0] data;
	} pbs_fetch_rsp_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] node;
	} pbs_rx_evt_t;
endpackage

// ### verilog/pbs_unit.sv
// Status word, command interpreter and shared data window of the peer bus unit.
`include "pbs_defs.svh"
module pbs_unit #(
	parameter logic [7:0] HW_REV = 8'h02
) (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire pbs_pkg::pbs_rx_evt_t     rx_evt,
	input  wire logic                     bus_err_evt,
	input  wire logic                     alarm_limit,
	output pbs_pkg::pbs_tx_t              tx,
	input  wire logic                     tx_ready,
	output pbs_pkg::pbs_fetch_t           fetch,
	input  wire pbs_pkg::pbs_fetch_rsp_t  fetch_rsp,
	output logic                          term_on,
	output logic                          peer_mode,
	output logic      [3:0]               node_id,
	output logic      [2:0]               rate_code
);
	// ****************************************
	// Register bus decode
	// ****************************************
	logic        setup, wr, win_sel, mapped, cmd_go, term_ok;
	logic [11:0] off;
	logic [7:0]  code;
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite;
	assign off     = {paddr[11:2], 2'b00};
	assign win_sel = paddr[11:8] == `PBS_WIN_PAGE;
	assign mapped  = win_sel || off <= `PBS_OFF_OVERFLOW;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign cmd_go  = wr && off == `PBS_OFF_COMMAND;
	assign code    = pwdata[7:0];
	assign term_ok = HW_REV >= `PBS_TERM_REV;

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] cmd_q, node_q, rate_q, src_q, count_q, first_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q   <= 8'h00;
			node_q  <= 8'h00;
			rate_q  <= `PBS_RATE_RESET;
			src_q   <= 8'h00;
			count_q <= 8'h00;
			first_q <= 8'h00;
		end else if (wr) begin
			unique case (off)
				`PBS_OFF_COMMAND:  cmd_q   <= code;
				`PBS_OFF_NODE:     node_q  <= pwdata[7:0];
				`PBS_OFF_RATE:     rate_q  <= pwdata[7:0];
				`PBS_OFF_SRC_NODE: src_q   <= pwdata[7:0];
				`PBS_OFF_COUNT:    count_q <= pwdata[7:0];
				`PBS_OFF_FIRST:    first_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Parameter checks
	// ****************************************
	logic node_ok, rate_ok, range_ok, src_ok, busy;
	logic [8:0] span;
	assign node_ok  = node_q >= `PBS_NODE_MIN && node_q <= `PBS_NODE_MAX;
	assign rate_ok  = rate_q >= `PBS_RATE_MIN && rate_q <= `PBS_RATE_MAX;
	assign src_ok   = src_q >= `PBS_NODE_MIN && src_q <= `PBS_NODE_MAX;
	assign span     = {1'b0, first_q} + {1'b0, count_q};
	// The range must also end inside the 64-entry window.
	assign range_ok = count_q != 8'h00 && count_q <= `PBS_COUNT_MAX
		&& first_q <= `PBS_FIRST_MAX && span <= {1'b0, `PBS_COUNT_MAX};
	logic go_init, go_send, go_copy, send_bad, copy_bad, init_bad;
	assign go_init  = cmd_go && !busy && code == `PBS_CMD_INIT;
	assign go_send  = cmd_go && !busy && code == `PBS_CMD_SEND;
	assign go_copy  = cmd_go && !busy && code == `PBS_CMD_COPY;
	assign init_bad = go_init && !(node_ok && rate_ok);
	assign send_bad = go_send && !range_ok;
	assign copy_bad = go_copy && !(range_ok && src_ok);

	// ****************************************
	// Peer mode set-up
	// ****************************************
	logic       peer_q, term_q;
	logic [3:0] node_act_q;
	logic [2:0] rate_act_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			peer_q     <= 1'b0;
			node_act_q <= 4'h2;
			rate_act_q <= 3'h7;
		end else if (go_init) begin
			peer_q     <= 1'b1;
			node_act_q <= node_ok ? node_q[3:0] : 4'h2;
			rate_act_q <= rate_ok ? rate_q[2:0] : 3'h7;
		end
	end
	// Termination commands act even while busy; they do not touch the data path.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			term_q <= 1'b1;
		end else if (cmd_go && term_ok && code == `PBS_CMD_TERM_OFF) begin
			term_q <= 1'b0;
		end else if (cmd_go && code == `PBS_CMD_TERM_ON) begin
			term_q <= 1'b1;
		end
	end
	assign term_on   = term_q;
	assign peer_mode = peer_q;
	assign node_id   = node_act_q;
	assign rate_code = rate_act_q;

	// ****************************************
	// Transfer engine
	// ****************************************
	pbs_pkg::pbs_state_t state_q;
	pbs_pkg::pbs_tx_t    tx_q;
	pbs_pkg::pbs_fetch_t fetch_q;
	logic [6:0]  left_q;
	logic [23:0] win [64];
	logic        tx_step, cp_step;
	logic [5:0]  nxt;
	assign busy    = state_q != pbs_pkg::ST_IDLE;
	assign tx_step = state_q == pbs_pkg::ST_SEND && tx_q.valid && tx_ready;
	assign cp_step = state_q == pbs_pkg::ST_COPY && fetch_rsp.valid;
	assign nxt     = state_q == pbs_pkg::ST_SEND ? tx_q.index + 6'h01 : fetch_q.index + 6'h01;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pbs_pkg::ST_IDLE;
			tx_q    <= '0;
			fetch_q <= '0;
			left_q  <= 7'h00;
		end else begin
			unique case (state_q)
				pbs_pkg::ST_IDLE: begin
					if (go_send && range_ok) begin
						state_q <= pbs_pkg::ST_SEND;
						tx_q    <= '{1'b1, first_q[5:0], win[first_q[5:0]]};
						left_q  <= count_q[6:0];
					end else if (go_copy && range_ok && src_ok) begin
						state_q <= pbs_pkg::ST_COPY;
						fetch_q <= '{1'b1, src_q[3:0], first_q[5:0]};
						left_q  <= count_q[6:0];
					end
				end
				pbs_pkg::ST_SEND: begin
					if (tx_step && left_q == 7'h01) begin
						state_q <= pbs_pkg::ST_IDLE;
						tx_q    <= '0;
					end else if (tx_step) begin
						tx_q   <= '{1'b1, nxt, win[nxt]};
						left_q <= left_q - 7'h01;
					end
				end
				pbs_pkg::ST_COPY: begin
					if (cp_step && left_q == 7'h01) begin
						state_q <= pbs_pkg::ST_IDLE;
						fetch_q <= '0;
					end else if (cp_step) begin
						fetch_q.index <= nxt;
						left_q        <= left_q - 7'h01;
					end
				end
			endcase
		end
	end
	assign tx    = tx_q;
	assign fetch = fetch_q;

	// The copy engine wins over a host write in the same cycle; the host is
	// expected to leave the window alone while busy.
	always_ff @(posedge clock) begin
		if (cp_step) begin
			win[fetch_q.index] <= fetch_rsp.data;
		end else if (wr && win_sel) begin
			win[paddr[7:2]] <= pwdata[23:0];
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	logic [11:0] rx_q, ovf_q, rx_hit, rx_clr;
	logic        berr_q, perr_q, st_wr;
	assign st_wr  = wr && off == `PBS_OFF_STATUS;
	assign rx_hit = rx_evt.valid && rx_evt.node >= 4'h2 && rx_evt.node <= 4'hD
		? 12'h001 << (rx_evt.node - 4'h2) : 12'h000;
	assign rx_clr = st_wr ? ~pwdata[11:0] : 12'h000;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_q  <= 12'h000;
			ovf_q <= 12'h000;
		end else begin
			rx_q  <= (rx_q & ~rx_clr) | rx_hit;
			// Clearing a receive flag acknowledges its overflow bit.
			ovf_q <= (ovf_q & ~(rx_clr & rx_q)) | (rx_hit & rx_q);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			berr_q <= 1'b0;
		end else if (bus_err_evt) begin
			berr_q <= 1'b1;
		end else if (go_send) begin
			berr_q <= 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			perr_q <= 1'b0;
		end else if (init_bad || send_bad || copy_bad) begin
			perr_q <= 1'b1;
		end else if (go_init || go_send || go_copy) begin
			perr_q <= 1'b0;
		end
	end
	logic [23:0] status;
	always_comb begin
		status                    = 24'h000000;
		status[11:0]              = rx_q;
		status[`PBS_BIT_BUS_ERR]  = berr_q;
		status[`PBS_BIT_BUSY]     = busy;
		status[`PBS_BIT_OVF]      = |ovf_q;
		status[`PBS_BIT_PARAM]    = perr_q;
		status[`PBS_BIT_ALARM]    = alarm_limit;
		status[`PBS_BIT_TERM_OFF] = term_ok && !term_q;
		status[`PBS_BIT_PEER]     = peer_q;
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (setup && win_sel) begin
			prdata <= {8'h00, win[paddr[7:2]]};
		end else if (setup) begin
			unique case (off)
				`PBS_OFF_STATUS:   prdata <= {8'h00, status};
				`PBS_OFF_COMMAND:  prdata <= {24'h000000, cmd_q};
				`PBS_OFF_NODE:     prdata <= {24'h000000, node_q};
				`PBS_OFF_RATE:     prdata <= {24'h000000, rate_q};
				`PBS_OFF_SRC_NODE: prdata <= {24'h000000, src_q};
				`PBS_OFF_COUNT:    prdata <= {24'h000000, count_q};
				`PBS_OFF_FIRST:    prdata <= {24'h000000, first_q};
				`PBS_OFF_OVERFLOW: prdata <= {20'h00000, ovf_q};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	rx_flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_evt.valid && rx_evt.node == 4'h2 |=> rx_q[0])
		else $error("receive flag for node 2 not set");
	status_hi_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_wr && !go_send && !bus_err_evt |=> $stable(berr_q) && $stable(perr_q))
		else $error("status write changed a protected bit");
	busy_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_send && range_ok |=> status[`PBS_BIT_BUSY] && tx.valid && tx.index == first_q[5:0])
		else $error("accepted send not busy");
	bad_send_a: assert property (@(posedge clock) disable iff (!rst_n)
		send_bad |=> (perr_q && !busy && !tx.valid) [*2])
		else $error("invalid send was not aborted");
	bad_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
		copy_bad |=> perr_q && !fetch.valid)
		else $error("invalid copy was not aborted");
	init_node_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_init && !node_ok |=> node_id == 4'h2 && perr_q && peer_mode)
		else $error("invalid node not replaced by 2");
	init_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_init && !rate_ok |=> rate_code == 3'h7 && perr_q)
		else $error("invalid rate did not fall back");
	berr_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_send && !bus_err_evt |=> !status[`PBS_BIT_BUS_ERR])
		else $error("bus error not cleared by send");
	term_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_go && code == `PBS_CMD_TERM_OFF && term_ok |=> !term_on && status[22])
		else $error("termination not switched off");
	cmd_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_go |=> cmd_q == $past(code))
		else $error("command readback wrong");
	rx_flag_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		st_wr && !rx_evt.valid && !pwdata[0] |=> !rx_q[0])
		else $error("receive flag not cleared by host write");
	ovf_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_evt.valid && rx_evt.node == 4'hD && rx_q[11] |=> ovf_q[11] && status[14])
		else $error("repeated receive did not flag overflow");
	berr_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		bus_err_evt |=> status[`PBS_BIT_BUS_ERR])
		else $error("bus error not reported");
	perr_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_init && node_ok && rate_ok |=> !perr_q)
		else $error("valid init left parameter error set");
	peer_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_init |=> status[`PBS_BIT_PEER] && peer_mode)
		else $error("peer mode not reported after init");
	init_take_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_init && node_ok && rate_ok
		|=> node_id == $past(node_q[3:0]) && rate_code == $past(rate_q[2:0]))
		else $error("init did not adopt configured node and rate");
	copy_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		go_copy && range_ok && src_ok |=> busy && fetch.valid
		&& fetch.index == first_q[5:0] && fetch.node == src_q[3:0])
		else $error("accepted copy did not start fetching");
	send_step_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_step && left_q != 7'h01 |=> tx.valid && tx.index == $past(tx_q.index) + 6'h01)
		else $error("send did not advance to next entry");
	send_done_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_step && left_q == 7'h01 |=> !busy && !tx.valid)
		else $error("busy not dropped after last entry");
	term_on_a: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_go && code == `PBS_CMD_TERM_ON |=> term_on && !status[`PBS_BIT_TERM_OFF])
		else $error("termination not switched on");
endmodule

// ### verification/pbs_peer.sv
// Behavioural model of the other bus nodes facing the peer unit.
module pbs_peer (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    slow,
	input  wire pbs_pkg::pbs_tx_t        tx,
	input  wire pbs_pkg::pbs_fetch_t     fetch,
	output logic                         tx_ready,
	output pbs_pkg::pbs_fetch_rsp_t      fetch_rsp,
	output logic [7:0]                   tx_seen,
	output logic [29:0]                  tx_last
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph_q;
	// A slow peer accepts only one cycle in four, so busy stays visible to the host.
	assign tx_ready = !slow || (ph_q == 2'h3);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 2'h0;
			tx_seen <= 8'h00;
			tx_last <= 30'h0;
			fetch_rsp <= '0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (tx.valid && tx_ready) begin
				tx_seen <= tx_seen + 8'h01;
				tx_last <= {tx.index, tx.data};
			end
			if (fetch.valid && !fetch_rsp.valid && tx_ready) begin
				fetch_rsp.valid <= 1'b1;
				fetch_rsp.data <= {10'h2A5, fetch.node, fetch.index, 4'h9};
			end else begin
				// Idle data is inverted each cycle, so a stale value returns only every second cycle.
				fetch_rsp.valid <= 1'b0;
				fetch_rsp.data <= ~fetch_rsp.data;
			end
		end
	end
endmodule

// ### verification/tb.sv
// Self-checking bench of the peer status and command unit.
`include "pbs_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, perr, bus_err_evt;
	logic alarm_limit, tx_ready, term_on, peer_mode, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] node_id;
	logic [2:0] rate_code;
	logic [7:0] tx_seen;
	logic [29:0] tx_last;
	pbs_pkg::pbs_rx_evt_t rx_evt;
	pbs_pkg::pbs_tx_t tx;
	pbs_pkg::pbs_fetch_t fetch;
	pbs_pkg::pbs_fetch_rsp_t fetch_rsp;
	int mismatches = 0;
	int checks = 0;
	pbs_unit u_pbs_unit (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_evt(rx_evt), .bus_err_evt(bus_err_evt),
		.alarm_limit(alarm_limit), .tx(tx), .tx_ready(tx_ready), .fetch(fetch),
		.fetch_rsp(fetch_rsp), .term_on(term_on), .peer_mode(peer_mode), .node_id(node_id),
		.rate_code(rate_code));
	pbs_peer u_pbs_peer (.clock(clock), .rst_n(rst_n), .slow(slow), .tx(tx), .fetch(fetch),
		.tx_ready(tx_ready), .fetch_rsp(fetch_rsp), .tx_seen(tx_seen), .tx_last(tx_last));
	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; holds the request until pready is sampled high.
	// One idle edge follows each transfer, so psel is never lowered and raised in one step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask
	function automatic logic [11:0] win(input logic [5:0] i);
		return {`PBS_WIN_PAGE, i, 2'b00};
	endfunction
	task automatic wait_idle();
		logic [31:0] r;
		int n;
		n = 0;
		do begin
			apb(1'b0, `PBS_OFF_STATUS, 32'h0, r);
			n++;
		end while (r[13] !== 1'b0 && n < 100);
		chk({31'h0, r[13]}, 32'h0);
	endtask
	task automatic evt(input logic [3:0] n);
		rx_evt <= '{valid: 1'b1, node: n};
		@(posedge clock);
		rx_evt <= '0;
		@(posedge clock);
	endtask
	task automatic init(input logic [7:0] n, input logic [7:0] r);
		wr(`PBS_OFF_NODE, {24'h0, n});
		wr(`PBS_OFF_RATE, {24'h0, r});
		wr(`PBS_OFF_COMMAND, 32'h0A);
		rd(`PBS_OFF_STATUS, 32'h808000, 32'h800000);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(`PBS_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
		rd(`PBS_OFF_COMMAND, 32'hFFFFFFFF, 32'h0);
		rd(`PBS_OFF_RATE, 32'hFF, 32'h7);
		chk({31'h0, term_on}, 32'h1);
		rd(12'h020, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_rx();
		evt(4'h2);
		evt(4'hD);
		rd(`PBS_OFF_STATUS, 32'hFFFFFF, 32'h801);
		evt(4'hD);
		rd(`PBS_OFF_STATUS, 32'hFFFFFF, 32'h4801);
		rd(`PBS_OFF_OVERFLOW, 32'hFFF, 32'h800);
		wr(`PBS_OFF_STATUS, 32'hFFFFFFFE);
		rd(`PBS_OFF_STATUS, 32'hFFFFFF, 32'h4800);
		wr(`PBS_OFF_STATUS, 32'hFFFFF7FF);
		rd(`PBS_OFF_STATUS, 32'hFFFFFF, 32'h0);
		rd(`PBS_OFF_OVERFLOW, 32'hFFF, 32'h0);
		$display("test rx done");
	endtask
	task automatic t_init();
		for (int r = 4; r < 8; r++) begin
			init(8'(r + 6), 8'(r));
			chk({24'h0, node_id, 1'b0, rate_code}, {28'(r + 6), 4'(r)});
			chk({31'h0, peer_mode}, 32'h1);
		end
		wr(`PBS_OFF_NODE, 32'h1);
		wr(`PBS_OFF_RATE, 32'h8);
		wr(`PBS_OFF_COMMAND, 32'h0A);
		rd(`PBS_OFF_STATUS, 32'h808000, 32'h808000);
		chk({24'h0, node_id, 1'b0, rate_code}, 32'h27);
		rd(`PBS_OFF_COMMAND, 32'hFFFFFFFF, 32'h0A);
		init(8'h03, 8'h06);
		$display("test init done");
	endtask
	task automatic t_term();
		wr(`PBS_OFF_COMMAND, 32'h0D);
		rd(`PBS_OFF_STATUS, 32'h400000, 32'h400000);
		chk({31'h0, term_on}, 32'h0);
		rd(`PBS_OFF_COMMAND, 32'hFFFFFFFF, 32'h0D);
		wr(`PBS_OFF_COMMAND, 32'h0E);
		rd(`PBS_OFF_STATUS, 32'h400000, 32'h0);
		chk({31'h0, term_on}, 32'h1);
		$display("test termination done");
	endtask
	task automatic t_send();
		logic [7:0] s;
		s = tx_seen;
		wr(win(6'd62), 32'hABCDE1);
		wr(win(6'd63), 32'h123456);
		wr(`PBS_OFF_COUNT, 32'h2);
		wr(`PBS_OFF_FIRST, 32'h3E);
		bus_err_evt <= 1'b1;
		@(posedge clock);
		bus_err_evt <= 1'b0;
		rd(`PBS_OFF_STATUS, 32'h1000, 32'h1000);
		wr(`PBS_OFF_COMMAND, 32'h0B);
		rd(`PBS_OFF_STATUS, 32'h3000, 32'h2000);
		wait_idle();
		chk({24'h0, tx_seen - s}, 32'h2);
		chk({2'h0, tx_last}, {2'h0, 6'd63, 24'h123456});
		wr(`PBS_OFF_FIRST, 32'h3F);
		wr(`PBS_OFF_COMMAND, 32'h0B);
		wait_idle();
		rd(`PBS_OFF_STATUS, 32'h8000, 32'h8000);
		chk({24'h0, tx_seen - s}, 32'h2);
		$display("test send done");
	endtask
	task automatic t_copy();
		wr(`PBS_OFF_SRC_NODE, 32'h7);
		wr(`PBS_OFF_FIRST, 32'h3);
		wr(`PBS_OFF_COMMAND, 32'h0C);
		wait_idle();
		rd(`PBS_OFF_STATUS, 32'h8000, 32'h0);
		rd(win(6'd3), 32'hFFFFFF, {10'h2A5, 4'h7, 6'h03, 4'h9});
		rd(win(6'd4), 32'hFFFFFF, {10'h2A5, 4'h7, 6'h04, 4'h9});
		wr(`PBS_OFF_SRC_NODE, 32'h9);
		wr(`PBS_OFF_COUNT, 32'h41);
		wr(`PBS_OFF_COMMAND, 32'h0C);
		wait_idle();
		rd(`PBS_OFF_STATUS, 32'h8000, 32'h8000);
		rd(win(6'd3), 32'hFFFFFF, {10'h2A5, 4'h7, 6'h03, 4'h9});
		alarm_limit <= 1'b1;
		rd(`PBS_OFF_STATUS, 32'h10000, 32'h10000);
		alarm_limit <= 1'b0;
		rd(`PBS_OFF_STATUS, 32'h10000, 32'h0);
		$display("test copy and alarm done");
	endtask
	// ****************************************
	// Clock, reset, sequence and watchdog
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		{rst_n, psel, penable, pwrite, bus_err_evt, alarm_limit, slow} = 7'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rx_evt = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		slow <= 1'b1;
		t_reset();
		t_rx();
		t_init();
		t_term();
		t_send();
		t_copy();
		give_verdict();
	end
	// The whole run needs a few hundred cycles; ten thousand means a hang.
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end
endmodule
